// [rtl/anreg_latch.sv]
`timescale 1ns/1ps
`default_nettype none
module anreg_latch
  import anreg_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // flag control
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic flag_q;

  // set beats clear so an event in the read cycle is kept
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      flag_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (set_i)
      begin
        flag_q <= 1'b1;
      end
      else if (clr_i)
      begin
        flag_q <= 1'b0;
      end
    end
  end

  assign flag_o = flag_q;
endmodule : anreg_latch
`default_nettype wire

// [rtl/anreg_pkg.sv]
`default_nettype none
package anreg_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  // register offsets on the management port
  localparam logic [ADDR_W-1:0] ADV_ADDR = 5'h04;
  localparam logic [ADDR_W-1:0] PEER_ADDR = 5'h05;
  localparam logic [ADDR_W-1:0] EXP_ADDR = 5'h06;
  // advertisement reset value and writable bits
  localparam logic [DATA_W-1:0] ADV_RESET = 16'h01E1;
  localparam logic [DATA_W-1:0] ADV_WR_MASK = 16'hE7FF;
  localparam logic [4:0] SEL_IEEE = 5'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [10:0] EXP_RSVD_ZERO = 11'h000;
  localparam logic LOCAL_NP_ABLE = 1'b1;
  localparam int unsigned EXP_NP_ABLE_BIT = 2;
  localparam int unsigned WORD_NP_BIT = 15;

  typedef struct packed {
    logic next_page;
    logic ack;
    logic advertise_far_failure;
    logic [1:0] rsvd;
    logic pause;
    logic t4;
    logic fd100;
    logic hd100;
    logic fd10;
    logic hd10;
    logic [4:0] selector;
  } anreg_adv_t;

  typedef struct packed {
    logic [10:0] rsvd;
    logic multi_tech_link_error;
    logic peer_supports_extra_pages;
    logic local_np_able;
    logic new_page_arrived;
    logic peer_negotiation_capable;
  } anreg_exp_t;

  // page handed over by the arbitration logic
  typedef struct packed {
    logic valid;
    logic is_next;
    logic [DATA_W-1:0] word;
  } anreg_rx_t;

  typedef enum logic [2:0] {
    PV_EMPTY = 3'b001,
    PV_BASE = 3'b010,
    PV_NEXT = 3'b100
  } anreg_view_t;

  function automatic logic anreg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
    anreg_hit = (addr == target);
  endfunction : anreg_hit
endpackage : anreg_pkg
`default_nettype wire

// [rtl/anreg_top.sv]
`timescale 1ns/1ps
`default_nettype none
module anreg_top
  import anreg_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // management register port
  input wire logic [ADDR_W-1:0] mgmt_addr_i,
  input wire logic mgmt_wr_i,
  input wire logic mgmt_rd_i,
  input wire logic [DATA_W-1:0] mgmt_wdata_i,
  output logic [DATA_W-1:0] mgmt_rdata_o,
  output logic mgmt_rvalid_o,
  // arbitration logic side
  input wire anreg_rx_t rx_page_i,
  input wire logic multi_tech_link_error_i,
  input wire logic peer_nway_able_i,
  input wire logic an_restart_i,
  input wire logic an_complete_i,
  // towards arbitration and status
  output anreg_adv_t adv_word_o,
  output logic np_enable_o,
  output logic peer_view_next_o,
  output logic regs_valid_o
);
  anreg_adv_t adv_q;
  anreg_adv_t adv_d;
  logic [DATA_W-1:0] peer_word_q;
  anreg_view_t view_q;
  anreg_view_t view_d;
  logic view_next_q;
  logic peer_np_able_q;
  logic peer_nway_q;
  logic regs_valid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic rvalid_q;
  logic adv_wr;
  logic exp_rd;
  logic page_accept;
  logic base_accept;
  logic pdf_flag;
  logic page_flag;
  anreg_exp_t exp_view;

  assign adv_wr = mgmt_wr_i && anreg_hit(mgmt_addr_i, ADV_ADDR);
  assign exp_rd = mgmt_rd_i && anreg_hit(mgmt_addr_i, EXP_ADDR);
  // a next page before any base page has no meaning and is dropped
  assign base_accept = rx_page_i.valid && !rx_page_i.is_next;
  assign page_accept = base_accept || (rx_page_i.valid && rx_page_i.is_next && (view_q != PV_EMPTY));

  // advertisement register
  always_comb
  begin
    adv_d = adv_q;
    if (adv_wr)
    begin
      adv_d = anreg_adv_t'(mgmt_wdata_i & ADV_WR_MASK);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      adv_q <= anreg_adv_t'(ADV_RESET);
    end
    else if (clk_en_i)
    begin
      adv_q <= adv_d;
    end
  end

  // the word goes out as held; the T4 bit is software's to keep clear
  assign adv_word_o = adv_q;
  assign np_enable_o = adv_q.next_page;

  // which layout the peer register shows
  always_comb
  begin
    view_d = view_q;
    case (view_q)
      PV_EMPTY:
      begin
        if (base_accept)
        begin
          view_d = PV_BASE;
        end
      end
      PV_BASE:
      begin
        if (rx_page_i.valid && rx_page_i.is_next)
        begin
          view_d = PV_NEXT;
        end
      end
      PV_NEXT:
      begin
        if (base_accept)
        begin
          view_d = PV_BASE;
        end
      end
      default:
      begin
        view_d = PV_EMPTY;
      end
    endcase
    if (an_restart_i)
    begin
      view_d = PV_EMPTY;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      view_q <= PV_EMPTY;
      view_next_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      view_q <= view_d;
      view_next_q <= (view_d == PV_NEXT);
    end
  end

  // registered copy so the status pin has no decode glitch
  assign peer_view_next_o = view_next_q;

  // received page stored whole; the view only changes how bits are read
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      peer_word_q <= DATA_ZERO;
    end
    else if (clk_en_i)
    begin
      if (an_restart_i)
      begin
        peer_word_q <= DATA_ZERO;
      end
      else if (page_accept)
      begin
        peer_word_q <= rx_page_i.word;
      end
    end
  end

  // peer capabilities
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      peer_np_able_q <= 1'b0;
      peer_nway_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      peer_nway_q <= peer_nway_able_i;
      if (an_restart_i)
      begin
        peer_np_able_q <= 1'b0;
      end
      else if (base_accept)
      begin
        peer_np_able_q <= rx_page_i.word[WORD_NP_BIT];
      end
    end
  end

  // latched-high flags cleared by an expansion read
  anreg_latch u_pdf_latch (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .set_i(multi_tech_link_error_i),
    .clr_i(exp_rd),
    .flag_o(pdf_flag)
  );

  anreg_latch u_page_latch (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .set_i(page_accept),
    .clr_i(exp_rd),
    .flag_o(page_flag)
  );

  always_comb
  begin
    exp_view.rsvd = EXP_RSVD_ZERO;
    exp_view.multi_tech_link_error = pdf_flag;
    exp_view.peer_supports_extra_pages = peer_np_able_q;
    exp_view.local_np_able = LOCAL_NP_ABLE;
    exp_view.new_page_arrived = page_flag;
    exp_view.peer_negotiation_capable = peer_nway_q;
  end

  // software should trust these registers only once this is high
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      regs_valid_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      regs_valid_q <= an_complete_i && !an_restart_i;
    end
  end

  assign regs_valid_o = regs_valid_q;

  // read path, one cycle of latency, unmapped reads give zero
  always_comb
  begin
    rdata_d = DATA_ZERO;
    if (anreg_hit(mgmt_addr_i, ADV_ADDR))
    begin
      rdata_d = adv_q;
    end
    else if (anreg_hit(mgmt_addr_i, PEER_ADDR))
    begin
      rdata_d = peer_word_q;
    end
    else if (anreg_hit(mgmt_addr_i, EXP_ADDR))
    begin
      rdata_d = exp_view;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      rdata_q <= DATA_ZERO;
      rvalid_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      rvalid_q <= mgmt_rd_i;
      if (mgmt_rd_i)
      begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign mgmt_rdata_o = rdata_q;
  assign mgmt_rvalid_o = rvalid_q;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_adv_write;
    clk_en_i && adv_wr |=> adv_word_o == $past(mgmt_wdata_i & ADV_WR_MASK);
  endproperty
  a_adv_write: assert property (p_adv_write)
    else $error("advertisement write not taken");

  property p_np_enable;
    clk_en_i && adv_wr && mgmt_wdata_i[WORD_NP_BIT] |=> np_enable_o;
  endproperty
  a_np_enable: assert property (p_np_enable)
    else $error("next-page enable missing after write");

  property p_sel_reset;
    disable iff (1'b0) !reset_n_i ##1 reset_n_i |-> adv_q.selector == SEL_IEEE;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("selector not 802.3 after reset");

  property p_rsvd_zero;
    adv_q.rsvd == 2'b00 && exp_view.rsvd == EXP_RSVD_ZERO;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits not zero");

  property p_view_next;
    clk_en_i && view_q == PV_BASE && rx_page_i.valid && rx_page_i.is_next && !an_restart_i |=> peer_view_next_o;
  endproperty
  a_view_next: assert property (p_view_next)
    else $error("peer view did not switch to next page");

  property p_page_capture;
    clk_en_i && page_accept && !an_restart_i |=> peer_word_q == $past(rx_page_i.word);
  endproperty
  a_page_capture: assert property (p_page_capture)
    else $error("peer page not read back as received");

  property p_peer_np_able;
    clk_en_i && base_accept && !an_restart_i |=> peer_np_able_q == $past(rx_page_i.word[WORD_NP_BIT]);
  endproperty
  a_peer_np_able: assert property (p_peer_np_able)
    else $error("peer next-page ability not captured");

  property p_pdf_set_hold;
    clk_en_i && multi_tech_link_error_i |=> pdf_flag ##1 (pdf_flag || $past(exp_rd && clk_en_i));
  endproperty
  a_pdf_set_hold: assert property (p_pdf_set_hold)
    else $error("parallel fault flag lost");

  property p_page_clear;
    clk_en_i && exp_rd && !page_accept |=> !page_flag;
  endproperty
  a_page_clear: assert property (p_page_clear)
    else $error("page flag not cleared by read");

  property p_page_set;
    clk_en_i && page_accept |=> page_flag;
  endproperty
  a_page_set: assert property (p_page_set)
    else $error("page flag not set on new page");

  property p_local_np;
    clk_en_i && exp_rd |=> mgmt_rvalid_o && mgmt_rdata_o[EXP_NP_ABLE_BIT];
  endproperty
  a_local_np: assert property (p_local_np)
    else $error("local next-page able bit not one");

  property p_valid;
    clk_en_i && an_restart_i |=> !regs_valid_o;
  endproperty
  a_valid: assert property (p_valid)
    else $error("registers flagged valid during restart");
endmodule : anreg_top
`default_nettype wire

// [tb/anreg_arb_model.sv]
`timescale 1ns/1ps
`default_nettype none
module anreg_arb_model
  import anreg_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // towards the register bank
  output var anreg_rx_t rx_page_o,
  output var logic multi_tech_link_error_o
);
  initial
  begin
    rx_page_o = '0;
    multi_tech_link_error_o = 1'b0;
  end

  // word is not held after the pulse: its inverse shows, so stale data cannot pass for a match
  task automatic send_page(input logic is_next, input logic [DATA_W-1:0] word);
    @(posedge sys_clk_i);
    #2;
    rx_page_o = {1'b1, is_next, word};
    @(posedge sys_clk_i);
    #2;
    rx_page_o = {1'b0, is_next, ~word};
  endtask : send_page

  task automatic pulse_fault();
    @(posedge sys_clk_i);
    #2;
    multi_tech_link_error_o = 1'b1;
    @(posedge sys_clk_i);
    #2;
    multi_tech_link_error_o = 1'b0;
  endtask : pulse_fault
endmodule : anreg_arb_model
`default_nettype wire

// [tb/anreg_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
module anreg_top_test
  import anreg_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  anreg_rx_t rx_page;
  logic par_fault;
  logic nway_able = 1'b0;
  logic restart = 1'b0;
  logic complete = 1'b0;
  anreg_adv_t adv_word;
  logic np_en;
  logic view_next;
  logic regs_valid;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 32'hec23_8c0d;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] base_w;
  logic [DATA_W-1:0] next_w;

  always #25 sys_clk = ~sys_clk;

  anreg_top dut (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .clk_en_i(clk_en), .mgmt_addr_i(addr),
    .mgmt_wr_i(wr), .mgmt_rd_i(rd), .mgmt_wdata_i(wdata), .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid),
    .rx_page_i(rx_page), .multi_tech_link_error_i(par_fault), .peer_nway_able_i(nway_able), .an_restart_i(restart),
    .an_complete_i(complete), .adv_word_o(adv_word), .np_enable_o(np_en), .peer_view_next_o(view_next),
    .regs_valid_o(regs_valid));

  anreg_arb_model arb (.sys_clk_i(sys_clk), .rx_page_o(rx_page), .multi_tech_link_error_o(par_fault));

  // expansion word as the flags should stand
  function automatic logic [DATA_W-1:0] exp_word(input logic pd, input logic np, input logic pr, input logic nw);
    exp_word = {EXP_RSVD_ZERO, pd, np, LOCAL_NP_ABLE, pr, nw};
  endfunction : exp_word

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic chk16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
    cmp_count++;
    if (got !== want)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, want);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic want);
    cmp_count++;
    if (got !== want)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, want);
    end
  endtask : chk1

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    #2;
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(posedge sys_clk);
    #2;
    wr = 1'b0;
    wdata = ~v;
  endtask : wr_reg

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    int n;
    @(posedge sys_clk);
    #2;
    addr = a;
    rd = 1'b1;
    @(posedge sys_clk);
    #2;
    rd = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4)
    begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    if (n == 4)
    begin
      err_total++;
      conclude();
    end
    else
    begin
      v = rdata;
    end
  endtask : rd_reg

  initial
  begin
    repeat (2) @(posedge sys_clk);
    #2;
    reset_n = 1'b1;
    chk16(adv_word, 16'h01E1);
    chk1(np_en, 1'b0);
    rd_reg(ADV_ADDR, d);
    chk16(d, 16'h01E1);
    rd_reg(EXP_ADDR, d);
    chk16(d, exp_word(1'b0, 1'b0, 1'b0, 1'b0));
    for (int i = 0; i < 10; i++)
    begin
      d = 16'($random(seed));
      if (i == 0)
        d = 16'hFFFF;
      if (i == 1)
        d = 16'h0000;
      d[9] = 1'b0;
      wr_reg(ADV_ADDR, d);
      chk16(adv_word, d & 16'hE7FF);
      chk1(np_en, d[15]);
      rd_reg(ADV_ADDR, base_w);
      chk16(base_w, d & 16'hE7FF);
    end
    // frozen clock enable must drop the write
    clk_en = 1'b0;
    wr_reg(ADV_ADDR, ~d);
    clk_en = 1'b1;
    chk16(adv_word, d & 16'hE7FF);
    wr_reg(PEER_ADDR, 16'hFFFF);
    wr_reg(EXP_ADDR, 16'hFFFF);
    rd_reg(5'h1F, base_w);
    chk16(base_w, DATA_ZERO);
    nway_able = 1'b1;
    base_w = 16'($random(seed));
    base_w[15] = 1'b1;
    arb.send_page(1'b0, base_w);
    chk1(view_next, 1'b0);
    rd_reg(PEER_ADDR, d);
    chk16(d, base_w);
    rd_reg(EXP_ADDR, d);
    chk16(d, exp_word(1'b0, 1'b1, 1'b1, 1'b1));
    rd_reg(EXP_ADDR, d);
    chk16(d, exp_word(1'b0, 1'b1, 1'b0, 1'b1));
    for (int i = 0; i < 4; i++)
    begin
      next_w = 16'($random(seed));
      arb.send_page(1'b1, next_w);
      chk1(view_next, 1'b1);
      rd_reg(PEER_ADDR, d);
      chk16(d, next_w);
    end
    rd_reg(EXP_ADDR, d);
    chk16(d, exp_word(1'b0, 1'b1, 1'b1, 1'b1));
    arb.pulse_fault();
    rd_reg(EXP_ADDR, d);
    chk16(d, exp_word(1'b1, 1'b1, 1'b0, 1'b1));
    rd_reg(EXP_ADDR, d);
    chk16(d, exp_word(1'b0, 1'b1, 1'b0, 1'b1));
    complete = 1'b1;
    @(posedge sys_clk);
    #2;
    chk1(regs_valid, 1'b1);
    restart = 1'b1;
    @(posedge sys_clk);
    #2;
    restart = 1'b0;
    chk1(regs_valid, 1'b0);
    chk1(view_next, 1'b0);
    // a next page with no base page held is refused
    arb.send_page(1'b1, 16'h5A5A);
    chk1(view_next, 1'b0);
    rd_reg(PEER_ADDR, d);
    chk16(d, DATA_ZERO);
    // reset in mid-run brings the defaults back
    reset_n = 1'b0;
    @(posedge sys_clk);
    #2;
    reset_n = 1'b1;
    chk16(adv_word, ADV_RESET);
    chk1(np_en, 1'b0);
    chk1(regs_valid, 1'b0);
    rd_reg(ADV_ADDR, d);
    chk16(d, ADV_RESET);
    conclude();
  end
endmodule : anreg_top_test
`default_nettype wire
